// File: rtl/btr_pkg.sv
// package: types and constants for the branch target resolution unit
package btr_pkg;
   // ----------------------------------------------------------------
   // instruction classes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BTR_OP_BRANCH      = 3'h0,
      BTR_OP_COND_BRANCH = 3'h1,
      BTR_OP_LINK        = 3'h2,
      BTR_OP_INDIRECT    = 3'h3,
      BTR_OP_INDIR_LINK  = 3'h4,
      BTR_OP_IF_ZERO     = 3'h5,
      BTR_OP_IF_NONZERO  = 3'h6,
      BTR_OP_BLOCK_PFX   = 3'h7
   } btr_op_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      btr_op_t     op;
      logic [31:0] pc;
      logic [31:0] disp;
      logic [31:0] operand;
      logic [3:0]  reg_idx;
      logic [2:0]  instr_len;
      logic        cond_pass;
      logic [3:0]  block_mask;
   } btr_instr_t;

   typedef struct packed {
      logic        taken;
      logic [31:0] target;
      logic        link_we;
      logic [3:0]  link_idx;
      logic [31:0] link_data;
      logic        fault;
      logic        range_err;
   } btr_result_t;

   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam logic [3:0]  BTR_LINK_REG      = 4'h e;
   localparam logic [3:0]  BTR_PC_REG        = 4'h f;
   localparam logic [3:0]  BTR_LOW_REG_MAX   = 4'h7;
   localparam logic [31:0] BTR_FAR_RANGE     = 32'h0100_0000;
   localparam logic [31:0] BTR_NEAR_RANGE    = 32'h0010_0000;
   localparam logic [31:0] BTR_CZ_MIN        = 32'h0000_0004;
   localparam logic [31:0] BTR_CZ_MAX        = 32'h0000_0082;
   localparam logic [2:0]  BTR_BLOCK_SLOTS   = 3'h4;
   localparam int          BTR_TARGET_LSB    = 0;
endpackage

// File: rtl/btr_unit.sv
// design: branch target resolution unit, one instruction per cycle
`timescale 1ns/10ps
// Operation
// - each branch jumps to pc-relative label or operand register value
// - linking forms write address of next instruction into register 14
// - indirect forms clear bit 0 of operand to form target
// - indirect forms with operand bit 0 clear raise illegal use fault
// - plain, linking and in-block conditional branch reach +/-16 MB
// - conditional branch outside a block reaches only +/-1 MB
// - indirect forms accept any 32-bit operand value, no range limit
// - only conditional branch may carry a condition outside a block
// - no branch instruction changes the condition flags
// - zero/nonzero forms jump on operand equal or unequal to zero
// - zero/nonzero forms take operand only from registers 0 to 7
// - zero/nonzero forms reach only 4 to 130 bytes forward
// - block prefix makes up to four following instructions conditional
module btr_unit
   import btr_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        instr_valid,
   input  wire btr_instr_t  instr,
   output logic             res_valid,
   output btr_result_t      res,
   output logic             fetch_redirect,
   output logic [31:0]      fetch_target,
   output logic             flush_younger,
   output logic             flags_we,
   output logic [2:0]       block_left
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // signed range check: -lim <= d < +lim
   function automatic logic in_range(input logic [31:0] d,
                                     input logic [31:0] lim);
      logic signed [32:0] sd;
      sd = {d[31], d};
      in_range = (sd < $signed({1'b0, lim})) &&
                 (sd >= -$signed({1'b0, lim}));
   endfunction

   // ----------------------------------------------------------------
   // block tracking
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BTR_ST_OUT   = 2'b01,
      BTR_ST_BLOCK = 2'b10
   } btr_state_t;

   btr_state_t  st_q, st_d;
   logic [2:0]  left_q, left_d;
   logic        in_block;
   logic        taken_c;

   always_comb begin
      st_d   = st_q;
      left_d = left_q;
      case (st_q)
         BTR_ST_OUT: begin
            if (instr_valid && instr.op == BTR_OP_BLOCK_PFX) begin
               // slot count from the mask's lowest set bit
               st_d = BTR_ST_BLOCK;
               if (instr.block_mask[0])
                  left_d = BTR_BLOCK_SLOTS;
               else if (instr.block_mask[1])
                  left_d = 3'h3;
               else if (instr.block_mask[2])
                  left_d = 3'h2;
               else
                  left_d = 3'h1;
            end
         end
         BTR_ST_BLOCK: begin
            if (instr_valid) begin
               left_d = left_q - 3'h1;
               if (left_q == 3'h1 || taken_c)
                  st_d = BTR_ST_OUT;
               if (taken_c)
                  left_d = 3'h0;
            end
         end
         default: begin
            st_d   = BTR_ST_OUT;
            left_d = 3'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // resolution
   // ----------------------------------------------------------------
   btr_result_t res_c;
   logic [31:0] rel_tgt;
   logic [31:0] next_pc;

   assign in_block = (st_q == BTR_ST_BLOCK);
   assign rel_tgt  = instr.pc + instr.disp;
   assign next_pc  = instr.pc + {29'h0, instr.instr_len};

   always_comb begin
      res_c         = '0;
      res_c.link_idx = BTR_LINK_REG;
      taken_c       = 1'b0;
      if (instr_valid) begin
         case (instr.op)
            BTR_OP_BRANCH, BTR_OP_LINK: begin
               res_c.range_err = !in_range(instr.disp, BTR_FAR_RANGE);
               taken_c = (!in_block || instr.cond_pass) &&
                         !res_c.range_err;
               res_c.target = rel_tgt;
               if (instr.op == BTR_OP_LINK && taken_c) begin
                  res_c.link_we   = 1'b1;
                  res_c.link_data = next_pc;
               end
            end
            BTR_OP_COND_BRANCH: begin
               res_c.range_err = in_block ?
                  !in_range(instr.disp, BTR_FAR_RANGE) :
                  !in_range(instr.disp, BTR_NEAR_RANGE);
               taken_c = instr.cond_pass && !res_c.range_err;
               res_c.target = rel_tgt;
            end
            BTR_OP_INDIRECT, BTR_OP_INDIR_LINK: begin
               // whole 32-bit value is legal, only bit 0 is checked
               res_c.target = {instr.operand[31:1], 1'b0};
               if (!in_block || instr.cond_pass) begin
                  if (!instr.operand[BTR_TARGET_LSB])
                     res_c.fault = 1'b1;
                  else
                     taken_c = 1'b1;
                  if (instr.op == BTR_OP_INDIR_LINK && taken_c) begin
                     res_c.link_we   = 1'b1;
                     res_c.link_data = next_pc;
                  end
               end
            end
            BTR_OP_IF_ZERO, BTR_OP_IF_NONZERO: begin
               res_c.range_err = (instr.reg_idx > BTR_LOW_REG_MAX) ||
                  (instr.disp < BTR_CZ_MIN) ||
                  (instr.disp > BTR_CZ_MAX);
               res_c.target = rel_tgt;
               taken_c = !res_c.range_err &&
                  ((instr.op == BTR_OP_IF_ZERO) ==
                   (instr.operand == 32'h0000_0000));
            end
            default: begin
               taken_c = 1'b0;
            end
         endcase
      end
      res_c.taken = taken_c;
   end

   // ----------------------------------------------------------------
   // output next values
   // ----------------------------------------------------------------
   // every output is a flop so fetch sees one clean edge per result
   logic        res_valid_d;
   btr_result_t res_d;
   logic        redirect_d;
   logic [31:0] target_d;
   logic        flush_d;
   logic        flags_we_d;

   always_comb begin
      res_valid_d = instr_valid && (instr.op != BTR_OP_BLOCK_PFX);
      res_d       = res_c;
      redirect_d  = taken_c;
      target_d    = res_c.target;
      flush_d     = taken_c;
      flags_we_d  = 1'b0;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q   <= BTR_ST_OUT;
         left_q <= 3'h0;
      end else begin
         st_q   <= st_d;
         left_q <= left_d;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         res_valid      <= 1'b0;
         res            <= '0;
         fetch_redirect <= 1'b0;
         fetch_target   <= 32'h0000_0000;
         flush_younger  <= 1'b0;
         flags_we       <= 1'b0;
         block_left     <= 3'h0;
      end else begin
         res_valid      <= res_valid_d;
         res            <= res_d;
         fetch_redirect <= redirect_d;
         fetch_target   <= target_d;
         flush_younger  <= flush_d;
         flags_we       <= flags_we_d;
         block_left     <= left_d;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_link_addr: assert property (
      instr_valid && taken_c &&
      (instr.op == BTR_OP_LINK || instr.op == BTR_OP_INDIR_LINK) |=>
      res.link_we && res.link_idx == BTR_LINK_REG &&
      res.link_data == $past(next_pc))
      else $error("link write missing or wrong");

   a_indir_lsb: assert property (
      fetch_redirect && res_valid |->
      !(res.target[0] && $past(instr.op) inside
        {BTR_OP_INDIRECT, BTR_OP_INDIR_LINK}))
      else $error("indirect target bit 0 not cleared");

   a_indir_fault: assert property (
      instr_valid && !in_block &&
      instr.op == BTR_OP_INDIRECT && !instr.operand[0] |=>
      res.fault && !fetch_redirect)
      else $error("missing illegal use fault");

   a_fault_nolink: assert property (
      res.fault |-> !res.link_we && !fetch_redirect)
      else $error("faulting branch wrote link or jumped");

   a_indir_target: assert property (
      instr_valid && !in_block && instr.operand[0] &&
      instr.op inside {BTR_OP_INDIRECT, BTR_OP_INDIR_LINK} |=>
      fetch_redirect &&
      fetch_target == ($past(instr.operand) & 32'hffff_fffe))
      else $error("indirect target not taken from operand");

   a_far_range: assert property (
      instr_valid &&
      instr.op == BTR_OP_BRANCH && !in_block &&
      instr.disp == 32'h00ff_fffe |=> fetch_redirect)
      else $error("far branch wrongly refused");

   a_near_range: assert property (
      instr_valid && !in_block &&
      instr.op == BTR_OP_COND_BRANCH && instr.disp == BTR_NEAR_RANGE
      |=> !fetch_redirect && res.range_err)
      else $error("near branch beyond range taken");

   a_cond_fail: assert property (
      instr_valid && instr.op == BTR_OP_COND_BRANCH &&
      !instr.cond_pass |=> !fetch_redirect)
      else $error("failed condition still branched");

   a_no_flags: assert property (
      res_valid |-> !flags_we)
      else $error("branch wrote flags");

   a_zero_test: assert property (
      instr_valid &&
      instr.op == BTR_OP_IF_ZERO && instr.reg_idx < 4'h8 &&
      instr.disp == BTR_CZ_MIN |=>
      fetch_redirect == ($past(instr.operand) == 32'h0000_0000))
      else $error("zero test wrong");

   a_low_reg: assert property (
      instr_valid &&
      instr.op == BTR_OP_IF_NONZERO && instr.reg_idx > 4'h7 |=>
      !fetch_redirect)
      else $error("high register accepted");

   a_cz_window: assert property (
      instr_valid &&
      instr.op == BTR_OP_IF_ZERO && instr.disp == 32'h0000_0084 |=>
      !fetch_redirect ##1 !flush_younger)
      else $error("zero branch beyond window taken");

   a_block_len: assert property (
      st_q == BTR_ST_OUT && instr_valid &&
      instr.op == BTR_OP_BLOCK_PFX && instr.block_mask[0] |=>
      block_left == 3'h4)
      else $error("block length wrong");

   a_block_exit: assert property (
      in_block && instr_valid && taken_c |=> !in_block)
      else $error("block kept open after taken branch");

   a_flush_pair: assert property (
      fetch_redirect |->
      flush_younger && fetch_target == res.target)
      else $error("redirect without flush");

   c_link_taken: cover property (res_valid && res.link_we);
   c_fault: cover property (res.fault);
   c_block_end: cover property (in_block ##1 !in_block);
   c_cz_taken: cover property (fetch_redirect && res_valid &&
      $past(instr.op) == BTR_OP_IF_NONZERO);

endmodule

// File: verification/btr_stream.sv
// partner model: instruction stream that feeds the resolution unit
`timescale 1ns/10ps
module btr_stream
   import btr_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       req,
   input  wire btr_instr_t req_instr,
   output logic            instr_valid,
   output btr_instr_t      instr
);
   btr_instr_t fixed;

   // the stream never names pc as the target of an indirect call
   always_comb begin
      fixed = req_instr;
      if (req_instr.op == BTR_OP_INDIR_LINK &&
          req_instr.reg_idx == BTR_PC_REG) begin
         fixed.reg_idx = 4'h0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         instr_valid <= 1'b0;
         instr       <= '0;
      end else if (req) begin
         instr_valid <= 1'b1;
         instr       <= fixed;
      end else begin
         // idle lines toggle so a stale word never looks live
         instr_valid <= 1'b0;
         instr       <= ~instr;
      end
   end
endmodule

// File: verification/branch_target_resolution_unit_tb.sv
// testbench: branch target resolution unit against the stream model
`timescale 1ns/10ps
module branch_target_resolution_unit_tb
   import btr_pkg::*;
;
   localparam logic [31:0] PC0 = 32'h0000_1000;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        req     = 1'b0;
   btr_instr_t  req_i   = '0;
   logic        instr_valid;
   btr_instr_t  instr;
   logic        res_valid;
   btr_result_t res;
   logic        fetch_redirect;
   logic [31:0] fetch_target;
   logic        flush_younger;
   logic        flags_we;
   logic [2:0]  block_left;
   int          errors = 0;
   int          check_count = 0;

   always #50 sys_clk = ~sys_clk;

   btr_stream i_stream (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
      .req_instr(req_i), .instr_valid(instr_valid), .instr(instr));

   btr_unit i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr(instr), .res_valid(res_valid),
      .res(res), .fetch_redirect(fetch_redirect),
      .fetch_target(fetch_target), .flush_younger(flush_younger),
      .flags_we(flags_we), .block_left(block_left));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic test_done;
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic btr_instr_t mk(btr_op_t op, logic [31:0] d,
      logic [31:0] v, logic [3:0] r, logic [2:0] l, logic c);
      mk = '{op, PC0, d, v, r, l, c, 4'h0};
   endfunction

   task automatic put(input btr_instr_t i);
      @(posedge sys_clk);
      req   <= 1'b1;
      req_i <= i;
   endtask

   // bounded wait for the one-cycle result pulse
   task automatic wait_res;
      for (int n = 0; n < 4; n++) begin
         @(posedge sys_clk);
         #1;
         if (res_valid === 1'b1) return;
      end
      errors++;
      test_done;
   endtask

   task automatic run(input btr_instr_t i);
      put(i);
      @(posedge sys_clk) req <= 1'b0;
      wait_res;
   endtask

   task automatic res_chk(input int t, input logic [31:0] g,
      input int w, input logic [31:0] d, input int f, input int e);
      chk("taken", 32'(res.taken), 32'(t));
      chk("redirect", 32'(fetch_redirect), 32'(t));
      chk("flush", 32'(flush_younger), 32'(t));
      chk("link_we", 32'(res.link_we), 32'(w));
      chk("fault", 32'(res.fault), 32'(f));
      chk("range_err", 32'(res.range_err), 32'(e));
      chk("flags_we", 32'(flags_we), 32'h0);
      if (t != 0) chk("target", fetch_target, g);
      if (w != 0) chk("link_data", res.link_data, d);
      if (w != 0) chk("link_idx", 32'(res.link_idx), 32'h000e);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_direct;
      run(mk(BTR_OP_LINK, 32'h0000_0020, 32'h0, 4'h0, 3'h4, 1'b1));
      res_chk(1, PC0 + 32'h0000_0020, 1, PC0 + 32'h0000_0004, 0, 0);
      run(mk(BTR_OP_BRANCH, 32'hFF00_0000, 32'h0, 4'h0, 3'h4, 1'b0));
      res_chk(1, PC0 + 32'hFF00_0000, 0, 0, 0, 0);
      run(mk(BTR_OP_BRANCH, 32'h00FF_FFFE, 32'h0, 4'h0, 3'h4, 1'b0));
      res_chk(1, PC0 + 32'h00FF_FFFE, 0, 0, 0, 0);
      run(mk(BTR_OP_BRANCH, 32'h0100_0000, 32'h0, 4'h0, 3'h4, 1'b1));
      res_chk(0, 0, 0, 0, 0, 1);
   endtask

   task automatic t_cond;
      run(mk(BTR_OP_COND_BRANCH, 32'hFFF0_0000, 32'h0, 4'h0, 3'h4, 1'b1));
      res_chk(1, PC0 + 32'hFFF0_0000, 0, 0, 0, 0);
      run(mk(BTR_OP_COND_BRANCH, 32'h0010_0000, 32'h0, 4'h0, 3'h4, 1'b1));
      res_chk(0, 0, 0, 0, 0, 1);
      run(mk(BTR_OP_COND_BRANCH, 32'h0000_0010, 32'h0, 4'h0, 3'h2, 1'b0));
      res_chk(0, 0, 0, 0, 0, 0);
   endtask

   task automatic t_indirect;
      run(mk(BTR_OP_INDIRECT, 32'h0, 32'h2000_0001, 4'h3, 3'h2, 1'b0));
      res_chk(1, 32'h2000_0000, 0, 0, 0, 0);
      run(mk(BTR_OP_INDIR_LINK, 32'h0, 32'hFFFF_FFFF, 4'h9, 3'h2, 1'b1));
      res_chk(1, 32'hFFFF_FFFE, 1, PC0 + 32'h0000_0002, 0, 0);
      run(mk(BTR_OP_INDIR_LINK, 32'h0, 32'h0000_1000, 4'h9, 3'h2, 1'b1));
      res_chk(0, 0, 0, 0, 1, 0);
   endtask

   // compare-zero forms are only ever issued outside a block
   task automatic t_zero;
      run(mk(BTR_OP_IF_ZERO, 32'h0000_0004, 32'h0, 4'h7, 3'h2, 1'b0));
      res_chk(1, PC0 + 32'h0000_0004, 0, 0, 0, 0);
      run(mk(BTR_OP_IF_NONZERO, 32'h0000_0082, 32'h0, 4'h0, 3'h2, 1'b0));
      res_chk(0, 0, 0, 0, 0, 0);
      run(mk(BTR_OP_IF_NONZERO, 32'h0000_0082, 32'h5, 4'h1, 3'h2, 1'b0));
      res_chk(1, PC0 + 32'h0000_0082, 0, 0, 0, 0);
      run(mk(BTR_OP_IF_ZERO, 32'h0000_0084, 32'h0, 4'h1, 3'h2, 1'b0));
      res_chk(0, 0, 0, 0, 0, 1);
      run(mk(BTR_OP_IF_ZERO, 32'h0000_0002, 32'h0, 4'h1, 3'h2, 1'b0));
      res_chk(0, 0, 0, 0, 0, 1);
      run(mk(BTR_OP_IF_ZERO, 32'h0000_0010, 32'h0, 4'h8, 3'h2, 1'b0));
      res_chk(0, 0, 0, 0, 0, 1);
      run(mk(BTR_OP_IF_NONZERO, 32'h0000_0010, 32'h5, 4'h9, 3'h2, 1'b0));
      res_chk(0, 0, 0, 0, 0, 1);
   endtask

   task automatic t_block;
      btr_instr_t p;
      p = mk(BTR_OP_BLOCK_PFX, 32'h0, 32'h0, 4'h0, 3'h2, 1'b1);
      p.block_mask = 4'h8;
      put(p);
      // the branch fills the single slot, so it is also the last one
      put(mk(BTR_OP_COND_BRANCH, 32'h0080_0000, 32'h0, 4'h0, 3'h4, 1'b1));
      @(posedge sys_clk) req <= 1'b0;
      #1 chk("block_left", 32'(block_left), 32'h1);
      wait_res;
      res_chk(1, PC0 + 32'h0080_0000, 0, 0, 0, 0);
      chk("block_end", 32'(block_left), 32'h0);
      p.block_mask = 4'h1;
      put(p);
      @(posedge sys_clk) req <= 1'b0;
      @(posedge sys_clk);
      #1 chk("block_four", 32'(block_left), 32'h4);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_direct;
      t_cond;
      t_indirect;
      t_zero;
      t_block;
      test_done;
   end
endmodule
